//--- shared/hpl_pkg.sv
// Package for the hub power and language configuration bank.
// Assumes a single 100 MHz core clock and byte-wide configuration access.
package hpl_pkg;

    // Byte addresses of the configuration registers.
    localparam logic [7:0] ADDR_MAX_POWER_SELF = 8'h0C;
    localparam logic [7:0] ADDR_MAX_POWER_BUS = 8'h0D;
    localparam logic [7:0] ADDR_CTRL_CURRENT_SELF = 8'h0E;
    localparam logic [7:0] ADDR_CTRL_CURRENT_BUS = 8'h0F;
    localparam logic [7:0] ADDR_POWER_GOOD_DELAY = 8'h10;
    localparam logic [7:0] ADDR_LANG_HIGH = 8'h11;
    localparam logic [7:0] ADDR_LANG_LOW = 8'h12;

    // Number of registers and their first address.
    localparam int NUM_REGS = 7;
    localparam logic [7:0] ADDR_FIRST = ADDR_MAX_POWER_SELF;

    // Storage index of each register (address minus first address).
    localparam int IDX_MAX_POWER_SELF = 0;
    localparam int IDX_MAX_POWER_BUS = 1;
    localparam int IDX_CTRL_CURRENT_SELF = 2;
    localparam int IDX_CTRL_CURRENT_BUS = 3;
    localparam int IDX_POWER_GOOD_DELAY = 4;
    localparam int IDX_LANG_HIGH = 5;
    localparam int IDX_LANG_LOW = 6;

    // Reset values; the current bytes reset to 50 decimal, i.e. 100 mA.
    localparam logic [7:0] RST_MAX_POWER_SELF = 8'h00;
    localparam logic [7:0] RST_MAX_POWER_BUS = 8'h00;
    localparam logic [7:0] RST_CTRL_CURRENT_SELF = 8'h32;
    localparam logic [7:0] RST_CTRL_CURRENT_BUS = 8'h32;
    localparam logic [7:0] RST_POWER_GOOD_DELAY = 8'h00;
    localparam logic [7:0] RST_LANG_HIGH = 8'h00;
    localparam logic [7:0] RST_LANG_LOW = 8'h00;

    // Value returned for an address outside the bank.
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    // Current fields count in steps of 2 mA.
    localparam int CURRENT_STEP_MA = 2;
    // The embedded peripheral of a compound hub reports no draw of its own.
    localparam logic [8:0] EMBEDDED_DRAW_MA = 9'h000;

    // Power-good delay counts in steps of 2 ms.
    localparam int DELAY_STEP_MS = 2;
    localparam int CLK_PERIOD_NS = 10;
    localparam int DELAY_STEP_CYCLES = DELAY_STEP_MS * 1000000 / CLK_PERIOD_NS;

    // Power-good timer states, one-hot.
    typedef enum logic [2:0] {
        HPL_T_IDLE = 3'b001,
        HPL_T_WAIT = 3'b010,
        HPL_T_GOOD = 3'b100
    } hpl_timer_e;

endpackage

//--- rtl/hpl_config.sv
// Configuration byte bank for hub power figures, power-good delay and language code.
// Assumes the configuration source writes bytes on the core clock and that
// the power mode and compound straps arrive asynchronously from pins.
//
// Notes on behaviour
// - Self-supplied max power counts 2 mA steps.
// - Bus-supplied max power counts 2 mA steps.
// - Embedded peripheral reports 0 mA when compound.
// - Self-supplied controller current counts 2 mA steps.
// - Self controller current resets to 50 decimal.
// - Bus-supplied controller current counts 2 mA steps.
// - Bus controller current resets to 50 decimal.
// - Power-good delay counts 2 ms steps.
// - Language high byte gives code bits 15:8.
// - Language low byte gives code bits 7:0.
//
// The bank holds seven byte registers at consecutive addresses. Each byte
// is loaded by a write strobe and read back one cycle after a read strobe.
// Nothing in the bank checks that a value is sensible: the ceilings on the
// self-supplied figures are the duty of whoever fills the bank.
//
// The descriptor outputs are all registered. A write therefore reaches them
// one clock edge after the write edge, and a strap change after three edges.
// The hub core is expected to sample them at its own pace, so the extra
// latency costs nothing while it keeps every descriptor output glitch free.
//
// The power-good timer counts whole delay units of the configured length.
// It reads the delay byte live, so a write during a wait takes effect at
// once; the configuration source should not do that during normal use.
`timescale 1ns/10ps
module hpl_config #(
    parameter int DELAY_STEP_CYCLES = hpl_pkg::DELAY_STEP_CYCLES
) (
    // Clock, reset and clock enable.
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic CE,
    // Configuration byte access.
    input wire logic CFG_WE,
    input wire logic CFG_RE,
    input wire logic [7:0] CFG_ADDR,
    input wire logic [7:0] CFG_WDATA,
    output logic [7:0] CFG_RDATA,
    output logic CFG_HIT,
    // Operating mode straps from pins.
    input wire logic SELF_POWERED,
    input wire logic COMPOUND,
    // Port power sequencing from the hub core.
    input wire logic PORT_POWER_ON,
    output logic PORT_POWER_GOOD,
    // Descriptor fields presented to the hub core.
    output logic [7:0] DESC_MAX_POWER,
    output logic [8:0] DESC_MAX_POWER_MA,
    output logic [7:0] DESC_CTRL_CURRENT,
    output logic [8:0] DESC_CTRL_CURRENT_MA,
    output logic [7:0] DESC_POWER_GOOD_DELAY,
    output logic [15:0] DESC_LANG_ID,
    output logic [8:0] DESC_EMBEDDED_MA,
    output logic DESC_SELF_POWERED
);

    // Reset value of each storage entry, indexed like the storage.
    localparam logic [7:0] RST_TABLE [hpl_pkg::NUM_REGS] = '{
        hpl_pkg::RST_MAX_POWER_SELF,
        hpl_pkg::RST_MAX_POWER_BUS,
        hpl_pkg::RST_CTRL_CURRENT_SELF,
        hpl_pkg::RST_CTRL_CURRENT_BUS,
        hpl_pkg::RST_POWER_GOOD_DELAY,
        hpl_pkg::RST_LANG_HIGH,
        hpl_pkg::RST_LANG_LOW
    };

    // Last count of one delay unit. Eighteen bits hold one unit at the core
    // clock; a shorter step is used only to keep simulation runs brief.
    localparam logic [17:0] STEP_LAST = 18'(DELAY_STEP_CYCLES - 1);
    // Scale factor from a current byte to milliamperes.
    localparam logic [8:0] STEP_MA = 9'(hpl_pkg::CURRENT_STEP_MA);

    // Register storage and access decode.
    logic [7:0] regs_q [hpl_pkg::NUM_REGS];
    logic [7:0] reg_index;
    logic addr_hit;
    logic [7:0] read_word;

    // Synchroniser stages; only the second stage feeds any logic.
    logic self_meta_q;
    logic self_sync_q;
    logic comp_meta_q;
    logic comp_sync_q;

    logic [7:0] sel_max_power;
    logic [7:0] sel_ctrl_current;
    // Values chosen by power mode, in raw bytes and in milliamperes.
    logic [8:0] sel_max_power_ma;
    logic [8:0] sel_ctrl_current_ma;
    logic [15:0] lang_code;

    // Power-good timer state and counters.
    hpl_pkg::hpl_timer_e state_q;
    hpl_pkg::hpl_timer_e state_d;
    logic [17:0] step_cnt_q;
    logic [17:0] step_cnt_d;
    logic [7:0] unit_cnt_q;
    logic [7:0] unit_cnt_d;
    logic step_done;
    logic units_done;

    // Address decode: the bank is a contiguous run of byte addresses.
    // The subtraction wraps for addresses below the bank, so the lower bound
    // is tested on the address itself and the upper bound on the index.
    assign reg_index = CFG_ADDR - hpl_pkg::ADDR_FIRST;
    assign addr_hit = (CFG_ADDR >= hpl_pkg::ADDR_FIRST) &&
                      (reg_index < 8'(hpl_pkg::NUM_REGS));
    assign CFG_HIT = addr_hit && (CFG_WE || CFG_RE);

    // Storage: one byte per register, each loaded when its address is written.
    // A write outside the bank matches no entry and is simply dropped.
    // The two controller current bytes come out of reset at 100 mA, the rest
    // at zero, so an unconfigured hub still reports a legal controller draw.
    generate
        for (genvar i = 0; i < hpl_pkg::NUM_REGS; i++) begin : g_reg
            logic wr_this;
            assign wr_this = CFG_WE && addr_hit && (reg_index == 8'(i));
            always_ff @(posedge CLK or negedge RESETN) begin
                if (!RESETN) begin
                    regs_q[i] <= RST_TABLE[i];
                end else if (CE && wr_this) begin
                    regs_q[i] <= CFG_WDATA;
                end
            end
        end
    endgenerate

    // Read-back selection; unmapped addresses return a fixed value.
    assign read_word = addr_hit ? regs_q[reg_index[2:0]] : hpl_pkg::READ_UNMAPPED;

    // Read data is registered so it is stable for the cycle after the request.
    // It then holds until the next read, so a slow reader may take its time.
    // A read and a write in the same cycle return the old contents.
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            CFG_RDATA <= 8'h00;
        end else if (CE && CFG_RE) begin
            CFG_RDATA <= read_word;
        end
    end

    // Two-stage synchronisers for the asynchronous mode straps.
    // The straps come from pins and may move at any time; reading the first
    // stage anywhere would let a metastable value spread into the selection.
    // Both straps reset low, so the bank starts in bus-supplied mode.
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            self_meta_q <= 1'b0;
            self_sync_q <= 1'b0;
            comp_meta_q <= 1'b0;
            comp_sync_q <= 1'b0;
        end else if (CE) begin
            self_meta_q <= SELF_POWERED;
            self_sync_q <= self_meta_q;
            comp_meta_q <= COMPOUND;
            comp_sync_q <= comp_meta_q;
        end
    end

    // The selection below uses only the synchronised mode, so the self and
    // bus figures never mix within one descriptor field.
    // Mode based selection.
    assign sel_max_power = self_sync_q ? regs_q[hpl_pkg::IDX_MAX_POWER_SELF]
                                       : regs_q[hpl_pkg::IDX_MAX_POWER_BUS];
    assign sel_ctrl_current = self_sync_q ? regs_q[hpl_pkg::IDX_CTRL_CURRENT_SELF]
                                          : regs_q[hpl_pkg::IDX_CTRL_CURRENT_BUS];

    // Scaling to milliamperes: a byte of 255 gives 510 mA, which needs nine
    // bits, hence the zero extension before the product.
    // Mode-selected value scaling.
    assign sel_max_power_ma = {1'b0, sel_max_power} * STEP_MA;
    assign sel_ctrl_current_ma = {1'b0, sel_ctrl_current} * STEP_MA;

    assign lang_code = {regs_q[hpl_pkg::IDX_LANG_HIGH], regs_q[hpl_pkg::IDX_LANG_LOW]};

    // Descriptor fields are registered so a mode change shows as one clean step.
    // The embedded peripheral reports no draw when the hub is compound, as its
    // consumption is already counted in the hub's own maximum-power figure.
    // Outside compound mode the field simply mirrors the selected figure.
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            DESC_MAX_POWER <= 8'h00;
            DESC_MAX_POWER_MA <= 9'h000;
            DESC_CTRL_CURRENT <= 8'h00;
            DESC_CTRL_CURRENT_MA <= 9'h000;
            DESC_POWER_GOOD_DELAY <= 8'h00;
            DESC_LANG_ID <= 16'h0000;
            DESC_EMBEDDED_MA <= 9'h000;
            DESC_SELF_POWERED <= 1'b0;
        end else if (CE) begin
            DESC_MAX_POWER <= sel_max_power;
            DESC_MAX_POWER_MA <= sel_max_power_ma;
            DESC_CTRL_CURRENT <= sel_ctrl_current;
            DESC_CTRL_CURRENT_MA <= sel_ctrl_current_ma;
            DESC_POWER_GOOD_DELAY <= regs_q[hpl_pkg::IDX_POWER_GOOD_DELAY];
            DESC_LANG_ID <= lang_code;
            DESC_EMBEDDED_MA <= comp_sync_q ? hpl_pkg::EMBEDDED_DRAW_MA : sel_max_power_ma;
            DESC_SELF_POWERED <= self_sync_q;
        end
    end

    // Power-good timer terminal conditions.
    // A delay of zero gives power good on the edge after the wait begins.
    assign step_done = (step_cnt_q == STEP_LAST);
    assign units_done = (unit_cnt_q == regs_q[hpl_pkg::IDX_POWER_GOOD_DELAY]);

    // Power good timing.
    // The timer runs while power-on is held, counting whole 2 ms units.
    // Dropping power-on mid-wait abandons the count; the idle state clears
    // both counters so the next request always starts from zero.
    // An unexpected state code falls back to idle through the default branch.
    always_comb begin
        state_d = state_q;
        step_cnt_d = step_cnt_q;
        unit_cnt_d = unit_cnt_q;
        case (state_q)
            hpl_pkg::HPL_T_IDLE: begin
                step_cnt_d = 18'h00000;
                unit_cnt_d = 8'h00;
                if (PORT_POWER_ON) begin
                    state_d = hpl_pkg::HPL_T_WAIT;
                end
            end
            hpl_pkg::HPL_T_WAIT: begin
                if (!PORT_POWER_ON) begin
                    state_d = hpl_pkg::HPL_T_IDLE;
                end else if (units_done) begin
                    state_d = hpl_pkg::HPL_T_GOOD;
                end else if (step_done) begin
                    step_cnt_d = 18'h00000;
                    unit_cnt_d = unit_cnt_q + 8'h01;
                end else begin
                    step_cnt_d = step_cnt_q + 18'h00001;
                end
            end
            hpl_pkg::HPL_T_GOOD: begin
                if (!PORT_POWER_ON) begin
                    state_d = hpl_pkg::HPL_T_IDLE;
                end
            end
            default: begin
                state_d = hpl_pkg::HPL_T_IDLE;
            end
        endcase
    end

    // Timer state registers; a low clock enable freezes the count.
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            state_q <= hpl_pkg::HPL_T_IDLE;
            step_cnt_q <= 18'h00000;
            unit_cnt_q <= 8'h00;
        end else if (CE) begin
            state_q <= state_d;
            step_cnt_q <= step_cnt_d;
            unit_cnt_q <= unit_cnt_d;
        end
    end

    // Power good is a registered level, dropped as soon as power-on falls.
    // It is taken from the next state so that it rises in step with the
    // timer entering the good state rather than one cycle later.
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            PORT_POWER_GOOD <= 1'b0;
        end else if (CE) begin
            PORT_POWER_GOOD <= (state_d == hpl_pkg::HPL_T_GOOD);
        end
    end

endmodule

//--- verif/hpl_checker.sv
// Concurrent checks on the hpl_config ports.
// Bound into every hpl_config instance; single clock domain.
`timescale 1ns/10ps
module hpl_checker (
    // Clock, reset and access.
    input wire logic CLK, RESETN, CE, CFG_WE, CFG_RE, CFG_HIT,
    input wire logic [7:0] CFG_ADDR, CFG_RDATA, DESC_MAX_POWER, DESC_CTRL_CURRENT,
    // Straps, timer and descriptor fields.
    input wire logic SELF_POWERED, COMPOUND, PORT_POWER_ON, PORT_POWER_GOOD,
    input wire logic DESC_SELF_POWERED,
    input wire logic [8:0] DESC_MAX_POWER_MA, DESC_CTRL_CURRENT_MA, DESC_EMBEDDED_MA
);
    // All checks share the core clock and reset.
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESETN);
    a_unmapped_read: assert property (CE && CFG_RE && !CFG_HIT |=> CFG_RDATA == 8'h00)
        else $error("unmapped read not zero");
    a_rdata_holds: assert property (!(CE && CFG_RE) |=> $stable(CFG_RDATA))
        else $error("read data moved without a read");
    a_hit_decode: assert property (CFG_HIT == ((CFG_WE || CFG_RE)
        && CFG_ADDR >= 8'h0C && CFG_ADDR <= 8'h12)) else $error("hit decode wrong");
    a_max_power_ma: assert property (DESC_MAX_POWER_MA == {DESC_MAX_POWER, 1'b0})
        else $error("max power scale wrong");
    a_ctrl_current_ma: assert property (DESC_CTRL_CURRENT_MA == {DESC_CTRL_CURRENT, 1'b0})
        else $error("controller current scale wrong");
    a_embedded_zero: assert property ((CE && COMPOUND)[*4] |-> DESC_EMBEDDED_MA == 9'h000)
        else $error("embedded draw not zero");
    a_mode_follows: assert property ((CE && $stable(SELF_POWERED))[*4]
        |-> DESC_SELF_POWERED == SELF_POWERED) else $error("power mode not followed");
    a_good_drops: assert property (CE && !PORT_POWER_ON |=> !PORT_POWER_GOOD)
        else $error("power good held without request");
    a_good_cause: assert property ($rose(PORT_POWER_GOOD) |-> $past(PORT_POWER_ON))
        else $error("power good without request");
    // Main scenarios reached.
    c_good: cover property (PORT_POWER_GOOD);
    c_write: cover property (CE && CFG_WE && CFG_HIT);
    c_compound_self: cover property (DESC_SELF_POWERED && DESC_EMBEDDED_MA == 9'h000);
endmodule
bind hpl_config hpl_checker hpl_checker_i (.CLK(CLK), .RESETN(RESETN), .CE(CE),
    .CFG_WE(CFG_WE), .CFG_RE(CFG_RE), .CFG_HIT(CFG_HIT), .CFG_ADDR(CFG_ADDR),
    .CFG_RDATA(CFG_RDATA), .DESC_MAX_POWER(DESC_MAX_POWER), .COMPOUND(COMPOUND),
    .DESC_CTRL_CURRENT(DESC_CTRL_CURRENT), .SELF_POWERED(SELF_POWERED),
    .PORT_POWER_ON(PORT_POWER_ON), .PORT_POWER_GOOD(PORT_POWER_GOOD),
    .DESC_SELF_POWERED(DESC_SELF_POWERED), .DESC_MAX_POWER_MA(DESC_MAX_POWER_MA),
    .DESC_CTRL_CURRENT_MA(DESC_CTRL_CURRENT_MA), .DESC_EMBEDDED_MA(DESC_EMBEDDED_MA));

//--- verif/hpl_host_model.sv
// Upstream host model that fetches descriptor fields from the hub.
// Assumes the fields are stable whenever a fetch is requested.
`timescale 1ns/10ps
module hpl_host_model (
    // Clock and fetch request.
    input wire logic clk, get,
    // Descriptor fields offered by the hub.
    input wire logic [8:0] emb_in,
    input wire logic [15:0] lang_in,
    // Values the host has seen.
    output logic [8:0] emb_q,
    output logic [15:0] lang_q
);
    always_ff @(posedge clk) begin
        if (get) begin
            emb_q <= emb_in;
            lang_q <= lang_in;
        end
    end
endmodule

//--- verif/tb.sv
// Self-checking bench for the hub power and language bank.
// Assumes the checker is bound and the timer step is shortened to 4 cycles.
`timescale 1ns/10ps
module tb;
    logic clk = 0, rst_n = 1, ce = 1, we = 0, re = 0, sp = 0, cmp = 0, on = 0, get = 0;
    logic [7:0] addr = 8'h00, wd = 8'h00, rdat, dmp, dcc, dpd, q;
    logic [8:0] dmp_ma, dcc_ma, emb, h_emb;
    logic [15:0] lang, h_lang;
    logic hit, good, dsp;
    int fails = 0, num_checks = 0, n;
    hpl_config #(.DELAY_STEP_CYCLES(4)) hpl_config_i (.CLK(clk), .RESETN(rst_n), .CE(ce),
        .CFG_WE(we), .CFG_RE(re), .CFG_ADDR(addr), .CFG_WDATA(wd), .CFG_RDATA(rdat),
        .CFG_HIT(hit), .SELF_POWERED(sp), .COMPOUND(cmp), .PORT_POWER_ON(on),
        .PORT_POWER_GOOD(good), .DESC_MAX_POWER(dmp), .DESC_MAX_POWER_MA(dmp_ma),
        .DESC_CTRL_CURRENT(dcc), .DESC_CTRL_CURRENT_MA(dcc_ma), .DESC_POWER_GOOD_DELAY(dpd),
        .DESC_LANG_ID(lang), .DESC_EMBEDDED_MA(emb), .DESC_SELF_POWERED(dsp));
    hpl_host_model hpl_host_model_i (.clk(clk), .get(get), .emb_in(emb), .lang_in(lang),
        .emb_q(h_emb), .lang_q(h_lang));
    // Free-running 100 MHz clock.
    initial forever #5 clk = ~clk;
    task automatic check(input string nm, input logic [15:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, d);
        @(posedge clk);
        we <= 1;
        addr <= a;
        wd <= d;
        @(posedge clk);
        we <= 0;
    endtask
    // Read waits an extra edge so the registered data has surely landed.
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        re <= 1;
        addr <= a;
        @(posedge clk);
        re <= 0;
        @(posedge clk);
        #1 d = rdat;
    endtask
    // Times a port power-on and checks the release when the request drops.
    task automatic pwr(input logic [7:0] d, input int lo, hi);
        wr(8'h10, d);
        @(posedge clk);
        on <= 1;
        n = 0;
        do begin
            @(posedge clk);
            #1 n++;
        end while (good !== 1'b1 && n < 200);
        if (n >= 200) begin
            fails++;
            complete_run();
        end
        check("pg_time", n >= lo && n <= hi, 1);
        @(posedge clk);
        on <= 0;
        @(posedge clk);
        #1 check("pg_drop", good, 0);
    endtask
    initial begin
        // A real falling edge so the asynchronous reset is seen by every hpl_config flop.
        rst_n <= 0;
        repeat (12) @(posedge clk);
        rst_n <= 1;
        for (int i = 0; i < 7; i++) begin
            rd(8'h0C + 8'(i), q);
            check("reset", q, (i == 2 || i == 3) ? 8'h32 : 8'h00);
        end
        check("ctrl_ma", dcc_ma, 9'h064);
        // Self-supplied values stay under 100 mA; configurer duty.
        for (int i = 0; i < 7; i++)
            wr(8'h0C + 8'(i), 8'(8'h10 + 5 * i));
        for (int i = 0; i < 7; i++) begin
            rd(8'h0C + 8'(i), q);
            check("readback", q, 8'(8'h10 + 5 * i));
        end
        wr(8'h13, 8'hFF);
        rd(8'h13, q);
        check("unmapped", q, 8'h00);
        ce <= 0;
        wr(8'h12, 8'hEE);
        ce <= 1;
        rd(8'h12, q);
        check("ce_off", q, 8'h2E);
        check("bus_max", dmp_ma, 9'h02A);
        check("bus_ctrl", dcc_ma, 9'h03E);
        check("delay", dpd, 8'h24);
        check("lang", lang, 16'h292E);
        @(posedge clk);
        sp <= 1;
        cmp <= 1;
        get <= 1;
        repeat (5) @(posedge clk);
        get <= 0;
        #1 check("self_max", dmp_ma, 9'h020);
        check("self_ctrl", dcc_ma, 9'h034);
        check("self_mode", dsp, 1);
        check("host_emb", h_emb, 9'h000);
        check("host_lang", h_lang, 16'h292E);
        pwr(8'h00, 2, 3);
        wr(8'h10, 8'h03);
        @(posedge clk);
        on <= 1;
        repeat (6) @(posedge clk);
        on <= 0;
        repeat (20) @(posedge clk);
        #1 check("abort", good, 0);
        pwr(8'h03, 12, 22);
        complete_run();
    end
endmodule
